// file: hdl/spp_pkg.sv
// Summary of operation
// - Parallel resistor only when config1 bit 11 set
// - Parallel value is signed span multiple, -8..+7.999
// - After measurement, post-process and store results
// - Start user program only when run bit is 1
// - Each half-bridge result has own gain factor, except half bridge 3 uses unity when parallel is on
// - Gain factors are 24-bit, config words 4 to 7
// - Span compensation scales gain, never the offset; the code only stores it as result 4
// - Temperature may replace span resistor as input
// - Supply correction applied only when enable is 1
// - Divide by one plus supply times ratio, shifted
// - Ground unused ports, keep measured port open
// - Grounding only when config12 bit 7 set
`timescale 1ns/1ps
`default_nettype none

package spp_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CFG1 = 8'h04;
  localparam logic [7:0] ADDR_GAIN0 = 8'h10;
  localparam logic [7:0] ADDR_CFG12 = 8'h30;
  localparam logic [7:0] ADDR_SUPPLY = 8'h34;
  localparam logic [7:0] ADDR_USER = 8'h38;
  localparam logic [7:0] ADDR_RESULT0 = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h54;
  // Field positions
  localparam int PAR_EN_BIT = 11;
  localparam int INT_RSPAN_BIT = 8;
  localparam int GROUND_EN_BIT = 7;
  localparam int SUP_EN_BIT = 8;
  localparam int FRAC = 20;
  localparam int SUP_SHIFT = 21;
  // Reset values and fixed-point constants
  localparam logic [23:0] CFG_RST = 24'h00_0000;
  localparam logic [23:0] GAIN_RST = 24'h10_0000;
  localparam logic [8:0] SUPPLY_RST = 9'h0F7;
  localparam logic [31:0] PAR_ONE = 32'h0010_0000;
  localparam logic [31:0] SUP_ONE = 32'h0020_0000;
  localparam logic [5:0] DIV_CYCLES = 6'h30;

  // Results of one raw measurement from the converter core
  typedef struct packed {
    logic [3:0][23:0] hb;
    logic [23:0] span;
    logic [23:0] temp;
    logic [23:0] supply;
  } spp_meas_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SPAN, ST_SPAN_WAIT, ST_MUL, ST_SUP, ST_SUP_WAIT, ST_STORE, ST_FINISH
  } spp_state_e;
endpackage : spp_pkg

// Restoring unsigned divider, one quotient bit per clock
module spp_divider (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [47:0] num,
  input wire logic [31:0] den,
  output logic [47:0] quo,
  output logic done
);
  logic [32:0] rem;
  logic [5:0] cnt;
  logic [32:0] trial;

  // Shift in the next dividend bit
  always_comb begin
    trial = {rem[31:0], quo[47]};
  end

  // Iterate for the full dividend width
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rem <= 33'h0_0000_0000;
      quo <= 48'h0000_0000_0000;
      cnt <= 6'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem <= 33'h0_0000_0000;
        quo <= num;
        cnt <= spp_pkg::DIV_CYCLES;
      end else if (cnt != 6'h00) begin
        if (trial >= {1'b0, den}) begin
          rem <= trial - {1'b0, den};
          quo <= {quo[46:0], 1'b1};
        end else begin
          rem <= trial;
          quo <= {quo[46:0], 1'b0};
        end
        cnt <= cnt - 6'h01;
        done <= (cnt == 6'h01);
      end
    end
  end
endmodule : spp_divider

`default_nettype wire

// file: hdl/spp_top.sv
`timescale 1ns/1ps
`default_nettype none

module spp_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic meas_done,
  input wire spp_pkg::spp_meas_s meas,
  input wire logic measuring,
  input wire logic [1:0] active_port,
  output logic [3:0] ground_drive,
  output logic user_program_start,
  output logic results_ready
);
  logic [23:0] cfg1;
  logic [23:0] cfg12;
  logic [8:0] supply_ctrl;
  logic user_run;
  logic [3:0][23:0] gain;
  logic [4:0][23:0] result;
  logic [7:0] meas_count;
  logic busy;
  logic wr_pend;
  logic rd_pend;
  logic [7:0] bus_addr;
  logic addr_ok;
  spp_pkg::spp_state_e state;
  spp_pkg::spp_meas_s snap;
  logic [1:0] idx;
  logic signed [23:0] acc;
  logic [23:0] span_eff;
  logic div_start;
  logic [47:0] div_num;
  logic [31:0] div_den;
  logic div_neg;
  logic [47:0] div_quo;
  logic div_done;
  logic par_en;
  logic sup_en;
  logic [23:0] comp_in;
  logic signed [48:0] par_num;
  logic signed [31:0] par_den;
  logic [23:0] gain_sel;
  logic signed [47:0] prod;
  logic signed [31:0] sup_prod;
  logic signed [31:0] sup_den;

  // Decode one register word address
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == spp_pkg::ADDR_CFG1) v = {8'h00, cfg1};
    if (a == spp_pkg::ADDR_CFG12) v = {8'h00, cfg12};
    if (a == spp_pkg::ADDR_SUPPLY) v = {23'h00_0000, supply_ctrl};
    if (a == spp_pkg::ADDR_USER) v = {31'h0000_0000, user_run};
    if (a == spp_pkg::ADDR_STATUS) v = {23'h00_0000, meas_count, busy};
    for (int i = 0; i < 4; i++) begin
      if (a == spp_pkg::ADDR_GAIN0 + 8'(4 * i)) v = {8'h00, gain[i]};
    end
    for (int i = 0; i < 5; i++) begin
      if (a == spp_pkg::ADDR_RESULT0 + 8'(4 * i)) v = {8'h00, result[i]};
    end
    return v;
  endfunction : reg_read

  // Port select to one-hot
  function automatic logic [3:0] port_hot(input logic [1:0] p);
    return 4'h1 << p;
  endfunction : port_hot

  // Magnitude of a signed product
  function automatic logic [47:0] mag48(input logic signed [48:0] v);
    logic [48:0] t;
    t = v[48] ? -v : v;
    return t[47:0];
  endfunction : mag48

  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    return v[31] ? -v : v;
  endfunction : mag32

  assign addr_ok = hsel & hready & htrans[1];

  // Bus phase tracking; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      bus_addr <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_ok & hwrite;
      rd_pend <= addr_ok & ~hwrite;
      hresp <= 1'b0;
      if (addr_ok) bus_addr <= haddr[7:0];
      hreadyout <= ~(addr_ok & ~hwrite);
      hrdata <= rd_pend ? reg_read(bus_addr) : 32'h0000_0000;
    end
  end

  // Configuration words written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg1 <= spp_pkg::CFG_RST;
      cfg12 <= spp_pkg::CFG_RST;
      supply_ctrl <= spp_pkg::SUPPLY_RST;
      user_run <= 1'b0;
    end else if (wr_pend) begin
      if (bus_addr == spp_pkg::ADDR_CFG1) cfg1 <= hwdata[23:0];
      if (bus_addr == spp_pkg::ADDR_CFG12) cfg12 <= hwdata[23:0];
      if (bus_addr == spp_pkg::ADDR_SUPPLY) supply_ctrl <= hwdata[8:0];
      if (bus_addr == spp_pkg::ADDR_USER) user_run <= hwdata[0];
    end
  end

  // One 24-bit gain word per half bridge
  for (genvar g = 0; g < 4; g++) begin : g_gain
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        gain[g] <= spp_pkg::GAIN_RST;
      end else if (wr_pend && bus_addr == spp_pkg::ADDR_GAIN0 + 8'(4 * g)) begin
        gain[g] <= hwdata[23:0];
      end
    end
  end

  // Arithmetic terms of the post-processing path
  always_comb begin
    par_en = cfg1[spp_pkg::PAR_EN_BIT];
    sup_en = supply_ctrl[spp_pkg::SUP_EN_BIT];
    comp_in = cfg1[spp_pkg::INT_RSPAN_BIT] ? snap.temp : snap.span;
    par_num = $signed({1'b0, comp_in}) * $signed(gain[3]);
    par_den = $signed({{8{gain[3][23]}}, gain[3]}) + $signed(spp_pkg::PAR_ONE);
    gain_sel = (idx == 2'd3 && par_en) ? spp_pkg::GAIN_RST : gain[idx];
    prod = $signed(snap.hb[idx]) * $signed(gain_sel);
    sup_prod = $signed(snap.supply) * $signed(supply_ctrl[7:0]);
    sup_den = sup_prod + $signed(spp_pkg::SUP_ONE);
  end

  // Post-processing sequence after each measurement
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= spp_pkg::ST_IDLE;
      snap <= '0;
      idx <= 2'd0;
      acc <= 24'h00_0000;
      span_eff <= 24'h00_0000;
      div_start <= 1'b0;
      div_num <= 48'h0000_0000_0000;
      div_den <= 32'h0000_0000;
      div_neg <= 1'b0;
      result <= '0;
    end else begin
      div_start <= 1'b0;
      unique case (state)
        spp_pkg::ST_IDLE: begin
          if (meas_done) begin
            snap <= meas;
            idx <= 2'd0;
            state <= spp_pkg::ST_SPAN;
          end
        end
        spp_pkg::ST_SPAN: begin
          if (par_en) begin
            div_start <= 1'b1;
            div_num <= mag48(par_num);
            div_den <= mag32(par_den);
            div_neg <= par_num[48] ^ par_den[31];
            state <= spp_pkg::ST_SPAN_WAIT;
          end else begin
            span_eff <= comp_in;
            state <= spp_pkg::ST_MUL;
          end
        end
        spp_pkg::ST_SPAN_WAIT: begin
          if (div_done) begin
            span_eff <= div_neg ? -div_quo[23:0] : div_quo[23:0];
            state <= spp_pkg::ST_MUL;
          end
        end
        spp_pkg::ST_MUL: begin
          // Pure scaling, so a zero input stays zero
          acc <= prod[spp_pkg::FRAC+23:spp_pkg::FRAC];
          state <= sup_en ? spp_pkg::ST_SUP : spp_pkg::ST_STORE;
        end
        spp_pkg::ST_SUP: begin
          div_start <= 1'b1;
          div_num <= {3'b000, (acc[23] ? -acc : acc), 21'h00_0000};
          div_den <= mag32(sup_den);
          div_neg <= acc[23] ^ sup_den[31];
          state <= spp_pkg::ST_SUP_WAIT;
        end
        spp_pkg::ST_SUP_WAIT: begin
          if (div_done) begin
            acc <= div_neg ? -div_quo[23:0] : div_quo[23:0];
            state <= spp_pkg::ST_STORE;
          end
        end
        spp_pkg::ST_STORE: begin
          result[idx] <= acc;
          idx <= idx + 2'd1;
          state <= (idx == 2'd3) ? spp_pkg::ST_FINISH : spp_pkg::ST_MUL;
        end
        spp_pkg::ST_FINISH: begin
          result[4] <= span_eff;
          state <= spp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Completion pulses and the run request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      results_ready <= 1'b0;
      user_program_start <= 1'b0;
      meas_count <= 8'h00;
      busy <= 1'b0;
    end else begin
      results_ready <= (state == spp_pkg::ST_FINISH);
      user_program_start <= (state == spp_pkg::ST_FINISH) && user_run;
      busy <= (state != spp_pkg::ST_IDLE);
      if (state == spp_pkg::ST_FINISH) meas_count <= meas_count + 8'h01;
    end
  end

  // Interference grounding of the idle ports
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ground_drive <= 4'h0;
    end else if (cfg12[spp_pkg::GROUND_EN_BIT] && measuring) begin
      ground_drive <= ~port_hot(active_port);
    end else begin
      ground_drive <= 4'h0;
    end
  end

  spp_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .quo(div_quo),
    .done(div_done)
  );

  ground_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !cfg12[spp_pkg::GROUND_EN_BIT] |=> ground_drive == 4'h0)
    else $error("grounding active while disabled");

  ground_port_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg12[spp_pkg::GROUND_EN_BIT] && measuring |=> ground_drive == ~(4'h1 << $past(active_port)))
    else $error("wrong port grounded");

  user_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    user_program_start |-> results_ready && $past(user_run))
    else $error("user program started without run bit");

  no_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == spp_pkg::ST_FINISH && !user_run |=> !user_program_start)
    else $error("user program started while run bit clear");

  par_bypass_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == spp_pkg::ST_SPAN && !par_en |=> state == spp_pkg::ST_MUL && !div_start)
    else $error("parallel resistor applied while disabled");

  div_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
    div_start |-> ##[48:50] div_done)
    else $error("divider did not finish in time");

  store_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == spp_pkg::ST_IDLE && meas_done |-> ##[8:400] results_ready)
    else $error("results not stored after measurement");

  sup_bypass_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == spp_pkg::ST_MUL && !sup_en |=> state == spp_pkg::ST_STORE)
    else $error("supply correction applied while disabled");

  gain_mul_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == spp_pkg::ST_MUL |=> acc == $past(prod[spp_pkg::FRAC+23:spp_pkg::FRAC]))
    else $error("gain product not taken");

  order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == spp_pkg::ST_SUP |-> $past(state) == spp_pkg::ST_MUL)
    else $error("supply correction before gain");

  okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hresp == 1'b0 and (rd_pend |-> !hreadyout ##1 hreadyout))
    else $error("bus response not okay");
endmodule : spp_top

`default_nettype wire

// file: dv/spp_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none

// Bridge ports: scans four ports, then hands over one raw measurement
module spp_bridge_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire spp_pkg::spp_meas_s values,
  output logic measuring,
  output logic [1:0] active_port,
  output logic meas_done,
  output var spp_pkg::spp_meas_s meas
);
  logic [3:0] cnt;

  // Scan sequence; meas is only valid in the done cycle, otherwise toggles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      measuring <= 1'b0;
      meas_done <= 1'b0;
      meas <= '0;
    end else begin
      meas_done <= 1'b0;
      meas <= ~meas;
      if (go && !measuring) begin
        measuring <= 1'b1;
        cnt <= 4'h0;
      end else if (measuring) begin
        cnt <= cnt + 4'h1;
        if (cnt == 4'h7) begin
          measuring <= 1'b0;
          meas_done <= 1'b1;
          meas <= values;
        end
      end
    end
  end

  assign active_port = cnt[2:1];
endmodule : spp_bridge_model

`default_nettype wire

// file: dv/test_spp_top.sv
`timescale 1ns/1ps
`default_nettype none

module test_spp_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, go = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, active_port;
  logic [2:0] hsize = 3'b010;
  logic hreadyout, hresp, meas_done, measuring, ups, rr, gen = 0, pm = 0;
  logic [1:0] pp = 0;
  logic [3:0] ground_drive;
  spp_pkg::spp_meas_s mv = '0, meas;
  int num_errors = 0, checks = 0, n;
  logic [31:0] rng = 32'hbe27_eb3a, g [4];

  always #50 hclk = ~hclk;
  assign hready = hreadyout;

  spp_top spp_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .meas_done(meas_done),
    .meas(meas), .measuring(measuring), .active_port(active_port),
    .ground_drive(ground_drive), .user_program_start(ups), .results_ready(rr));
  spp_bridge_model spp_bridge_model_inst (.hclk(hclk), .hresetn(hresetn), .go(go),
    .values(mv), .measuring(measuring), .active_port(active_port),
    .meas_done(meas_done), .meas(meas));

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  // Gain in 4.20, then optional supply division, truncated to 24 bits
  function automatic logic [31:0] eres(logic [23:0] hb, logic [31:0] gn, logic se, logic [23:0] s);
    longint p;
    p = ($signed({8'h0, hb}) * longint'($signed(gn))) >>> 20;
    if (se) p = (p <<< 21) / (longint'(2097152) + longint'($signed(s)) * -9);
    return {8'h0, p[23:0]};
  endfunction : eres

  // Span in parallel with k times itself: x*k/(1+k), k signed 4.20
  function automatic logic [31:0] espan(logic [23:0] x, logic [31:0] k);
    longint kk;
    longint p;
    kk = longint'($signed(k[23:0]));
    p = (longint'(x) * kk) / (kk + longint'(spp_pkg::PAR_ONE));
    return {8'h0, p[23:0]};
  endfunction : espan

  task automatic chk(string nm, logic [31:0] e, logic [31:0] v);
    checks++;
    if (v !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, v);
    end
  endtask : chk

  // One AHB-Lite single transfer; read data taken at the closing edge
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    bus(0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc

  task automatic meas_run(logic run);
    go <= 1;
    @(posedge hclk);
    go <= 0;
    for (n = 0; n < 400 && rr !== 1'b1; n++) @(posedge hclk);
    chk("results_ready", 1'b1, rr);
    chk("user_program_start", {31'h0, run}, {31'h0, ups});
  endtask : meas_run

  // Grounding follows enable, measuring and port of the previous cycle
  always @(posedge hclk) begin
    if (hresetn) chk("ground_drive", (gen && pm) ? ~(32'h1 << pp) & 32'hf : 0, ground_drive);
    pm <= measuring;
    pp <= active_port;
  end

  task automatic finish_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  initial begin
    #(100 * 20000);
    num_errors++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    for (int i = 0; i < 4; i++) rdc("gain reset", spp_pkg::ADDR_GAIN0 + 8'(4 * i), 32'h10_0000);
    rdc("supply reset", spp_pkg::ADDR_SUPPLY, 32'h0000_00f7);
    rdc("cfg1 reset", spp_pkg::ADDR_CFG1, 32'h0);
    rdc("unmapped", 8'h60, 32'h0);
    bus(1, spp_pkg::ADDR_RESULT0, 32'hffff_ffff);
    rdc("result read only", spp_pkg::ADDR_RESULT0, 32'h0);
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 4; i++) begin
        g[i] = 32'h8_0000 + (xs() & 32'hf_ffff);
        mv.hb[i] = xs() & 24'h1f_ffff;
        bus(1, spp_pkg::ADDR_GAIN0 + 8'(4 * i), g[i]);
      end
      mv.span = 24'(5 * (xs() & 32'h3_ffff));
      mv.temp = xs() & 24'hff_ffff;
      mv.supply = xs() & 24'h00_ffff;
      bus(1, spp_pkg::ADDR_SUPPLY, {23'h0, k[0], 8'hf7});
      bus(1, spp_pkg::ADDR_CFG12, {24'h0, k[0], 7'h0});
      gen = k[0];
      bus(1, spp_pkg::ADDR_USER, {31'h0, k[1]});
      bus(1, spp_pkg::ADDR_CFG1, {20'h0, k[2], 2'b00, k[1], 8'h0});
      meas_run(k[1]);
      rdc("status", spp_pkg::ADDR_STATUS, {23'h0, 8'(k + 1), 1'b0});
      if (k[2]) rdc("parallel span", spp_pkg::ADDR_RESULT0 + 8'h10, espan(k[1] ? mv.temp : mv.span, g[3]));
      else rdc("span source", spp_pkg::ADDR_RESULT0 + 8'h10, {8'h0, k[1] ? mv.temp : mv.span});
      if (k[2]) g[3] = spp_pkg::PAR_ONE;
      for (int i = 0; i < 4; i++) rdc("result", spp_pkg::ADDR_RESULT0 + 8'(4 * i), eres(mv.hb[i], g[i], k[0], mv.supply));
    end
    finish_test();
  end
endmodule : test_spp_top

`default_nettype wire
